// ==== dcc_checksum.sv ====
// DMA checksum generator with channel source and destination progress pointers.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
module dcc_checksum #(
   parameter int DATA_W = dcc_pkg::DATA_W,
   parameter int DEPTH  = dcc_pkg::FIFO_DEPTH
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic [7:0]        regAddr,
   input  wire logic [31:0]       regWdata,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic      [31:0]       regRdata,
   input  wire logic [DATA_W-1:0] moveData,
   input  wire logic              moveValid,
   output logic                   moveReady,
   input  wire logic              srcStep,
   input  wire logic              dstStep,
   input  wire logic              patternMatch,
   output logic                   busy
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [31:0]       control;
   logic [31:0]       sum;
   logic [31:0]       taps;
   logic [15:0]       srcPos;
   logic [15:0]       dstPos;
   logic [DATA_W-1:0] unitData;
   logic              unitValid;
   logic              unitTake;
   logic              fifoReady;
   logic              ipMode;
   logic [4:0]        polynomial_length;
   logic [31:0]       next_sum;
   logic [31:0]       readView;
   logic              wrControl;
   logic              wrValue;
   logic              wrTaps;
   logic              rdValue;
   // Only the low sixteen bits of the accumulator are used in IP mode.

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   // One strobe qualified by one register offset.
   function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
                                    input logic [7:0] offset);
      return strobe && (addr == offset);
   endfunction : reg_hit

   assign wrControl = reg_hit(regWrite, regAddr, dcc_pkg::OFF_CONTROL);
   assign wrValue   = reg_hit(regWrite, regAddr, dcc_pkg::OFF_VALUE);
   assign wrTaps    = reg_hit(regWrite, regAddr, dcc_pkg::OFF_TAPS);
   assign rdValue   = reg_hit(regRead, regAddr, dcc_pkg::OFF_VALUE);

   // The kind select applies at once; software reseeds after switching modes.
   // kind select bit
   assign ipMode   = control[dcc_pkg::KIND_BIT];
   // The length field names the top active stage, so zero still leaves one stage.
   assign polynomial_length     = control[dcc_pkg::POLYNOMIAL_LENGTH_LSB +: dcc_pkg::POLYNOMIAL_LENGTH_W];
   // Data is held off while software seeds, so a seed always precedes new data.
   // seed before data
   assign unitTake = unitValid && !wrValue;

   // -----------------------------------------------------------------
   // Input buffering
   // -----------------------------------------------------------------
   // The FIFO absorbs bursts while a seed write stalls the generator for a cycle.
   dcc_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) uFifo (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .inData   (moveData),
      .inValid  (moveValid),
      .inReady  (fifoReady),
      .outData  (unitData),
      .outValid (unitValid),
      .outReady (unitTake)
   );

   // -----------------------------------------------------------------
   // Arithmetic
   // -----------------------------------------------------------------
   // Mask of bits up to and including the top active stage.
   function automatic logic [31:0] len_mask(input logic [4:0] len);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 32; i++) begin
         m[i] = (5'(i) <= len);
      end
      return m;
   endfunction : len_mask

   // One data bit through a Galois shift register of length len+1.
   function automatic logic [31:0] lfsr_step(input logic [31:0] s, input logic [31:0] t,
                                             input logic [4:0] len, input logic b);
      logic [31:0] r;
      logic        fb;
      r  = '0;
      fb = s[len] ^ b;
      // Bits above the top stage are cleared at every step, so stale seed bits never show.
      for (int i = 1; i < 32; i++) begin
         r[i] = t[i] ? (s[i-1] ^ fb) : s[i-1];
      end
      r[0] = fb;
      return r & len_mask(len);
   endfunction : lfsr_step

   // Ones'-complement 16-bit addition with end-around carry.
   function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0000, s[16]};
   endfunction : oc_add

   always_comb begin
      next_sum = sum;
      if (ipMode) begin
         next_sum = {16'h0000, oc_add(sum[15:0], 16'(unitData))};
      end else begin
         // The whole unit is folded in one cycle, most significant bit first.
         for (int k = DATA_W-1; k >= 0; k--) begin
            next_sum = lfsr_step(next_sum, taps, polynomial_length, unitData[k]);
         end
      end
   end

   // -----------------------------------------------------------------
   // Registers written by software
   // -----------------------------------------------------------------
   // Only the implemented control fields are kept, so reserved bits read zero.
   // Writing the control register does not rework the accumulated value.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         control <= dcc_pkg::RESET_WORD;
      end else if (wrControl) begin
         control <= regWdata & dcc_pkg::CONTROL_MASK;
      end
   end

   // New taps take effect at the next unit; a unit taken in the same cycle uses the old ones.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         taps <= dcc_pkg::RESET_WORD;
      end else if (wrTaps) begin
         taps <= regWdata;
      end
   end

   // The accumulator holds the running sum; in IP mode the inverse is shown.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sum <= dcc_pkg::RESET_WORD;
      end else if (wrValue) begin
         sum <= ipMode ? {16'h0000, ~regWdata[15:0]} : regWdata;
      end else if (unitTake) begin
         sum <= next_sum;
      end
   end

   // -----------------------------------------------------------------
   // Channel pointers
   // -----------------------------------------------------------------
   // Both pointers count bytes, so a sixteen-bit counter covers the whole buffer.
   // A match with the pattern bit set outranks a step in the same cycle, so the pointer restarts at zero.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         srcPos <= dcc_pkg::RESET_POS;
      end else if (patternMatch && control[dcc_pkg::PATTERN_BIT]) begin
         srcPos <= dcc_pkg::RESET_POS;
      end else if (srcStep) begin
         srcPos <= srcPos + 16'h0001;
      end
   end

   // The pointer wraps from all ones to zero; no flag records the wrap.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dstPos <= dcc_pkg::RESET_POS;
      end else if (dstStep) begin
         dstPos <= dstPos + 16'h0001;
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   // Unmapped offsets read zero, and writes to the read-only pointers are ignored.
   always_comb begin
      case (regAddr)
         dcc_pkg::OFF_CONTROL: readView = control;
         dcc_pkg::OFF_VALUE: begin
            readView = ipMode ? {16'h0000, ~sum[15:0]} : (sum & len_mask(polynomial_length));
         end
         dcc_pkg::OFF_TAPS: readView = taps;
         dcc_pkg::OFF_SRCPOS: readView = {16'h0000, srcPos};
         dcc_pkg::OFF_DSTPOS: readView = {16'h0000, dstPos};
         // Status bit zero shows that the FIFO still holds data for the generator.
         dcc_pkg::OFF_STATUS: readView = {31'h0000_0000, unitValid};
         default: readView = 32'h0000_0000;
      endcase
   end

   // Read data stand only in the cycle after a read strobe and are zero otherwise,
   // so several slaves can share one read bus through a plain OR.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= dcc_pkg::RESET_WORD;
      end else if (regRead) begin
         regRdata <= readView;
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   // Ready is a registered copy of the FIFO's room and lags it by one cycle;
   // a push into a full FIFO is refused there, so the sender must honour ready.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         moveReady <= 1'b0;
         busy      <= 1'b0;
      end else begin
         moveReady <= fifoReady;
         busy      <= unitValid;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_seed_loads: assert property (@(posedge mclk) disable iff (!rst_n)
      regWrite && regAddr == dcc_pkg::OFF_VALUE && !ipMode |=> sum == $past(regWdata))
      else $error("seed not loaded");
   // These properties guard the checksum path, the bus answers and the channel pointers.
   a_read_live: assert property (@(posedge mclk) disable iff (!rst_n)
      rdValue && !ipMode
      |=> regRdata == ($past(sum) & len_mask($past(polynomial_length))))
      else $error("value read not live");
   a_upper_len_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      regRead && regAddr == dcc_pkg::OFF_VALUE && !ipMode && polynomial_length < 5'h1F
      |=> (regRdata >> ($past(polynomial_length) + 6'h01)) == 32'h0)
      else $error("bits above length set");
   a_ip_upper_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      regRead && regAddr == dcc_pkg::OFF_VALUE && ipMode |=> regRdata[31:16] == 16'h0000)
      else $error("ip upper half set");
   a_ip_complement: assert property (@(posedge mclk) disable iff (!rst_n)
      regWrite && regAddr == dcc_pkg::OFF_VALUE && ipMode ##1 !unitTake
      && regRead && regAddr == dcc_pkg::OFF_VALUE
      |=> regRdata == {16'h0000, $past(regWdata[15:0], 2)})
      else $error("ip value not returned");
   a_ptr_upper_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      regRead && (regAddr == dcc_pkg::OFF_SRCPOS || regAddr == dcc_pkg::OFF_DSTPOS)
      |=> regRdata[31:16] == 16'h0000)
      else $error("pointer upper bits set");
   a_match_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      patternMatch && control[dcc_pkg::PATTERN_BIT] |=> srcPos == 16'h0000)
      else $error("match did not clear source");
   a_dst_steps: assert property (@(posedge mclk) disable iff (!rst_n)
      dstStep |=> dstPos == $past(dstPos) + 16'h0001)
      else $error("destination did not step");
   a_unit_updates: assert property (@(posedge mclk) disable iff (!rst_n)
      unitTake |=> sum == $past(next_sum))
      else $error("checksum not updated");

   // -----------------------------------------------------------------
   // Checks on seeding, modes, taps, idle reads and reset
   // -----------------------------------------------------------------
   a_seed_first: assert property (@(posedge mclk) disable iff (!rst_n)
      wrValue |-> !unitTake)
      else $error("data taken during seed");
   a_kind_select: assert property (@(posedge mclk) disable iff (!rst_n)
      wrControl |=> ipMode == $past(regWdata[dcc_pkg::KIND_BIT]))
      else $error("kind select not taken");
   a_lfsr_masked: assert property (@(posedge mclk) disable iff (!rst_n)
      unitTake && !ipMode |=> (sum & ~len_mask($past(polynomial_length))) == 32'h0000_0000)
      else $error("stage above length set");
   a_ip_sum_upper: assert property (@(posedge mclk) disable iff (!rst_n)
      unitTake && ipMode |=> sum[31:16] == 16'h0000)
      else $error("ip sum upper half set");
   a_ip_no_taps: assert property (@(posedge mclk) disable iff (!rst_n)
      unitTake && ipMode
      |=> sum[15:0] == oc_add($past(sum[15:0]), 16'($past(unitData))))
      else $error("ip sum depends on more than data");
   a_taps_load: assert property (@(posedge mclk) disable iff (!rst_n)
      wrTaps |=> taps == $past(regWdata))
      else $error("taps not loaded");
   a_read_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      !regRead |=> regRdata == 32'h0000_0000)
      else $error("read data outside read cycle");
   // Reset is checked at the second edge, once the clocked reset branch has run.
   a_reset_clear: assert property (@(posedge mclk)
      !rst_n ##1 !rst_n |-> sum == dcc_pkg::RESET_WORD && taps == dcc_pkg::RESET_WORD
      && srcPos == dcc_pkg::RESET_POS && dstPos == dcc_pkg::RESET_POS)
      else $error("state not cleared by reset");

   // -----------------------------------------------------------------
   // Checks on the pointers
   // -----------------------------------------------------------------
   a_src_steps: assert property (@(posedge mclk) disable iff (!rst_n)
      srcStep && !(patternMatch && control[dcc_pkg::PATTERN_BIT])
      |=> srcPos == $past(srcPos) + 16'h0001)
      else $error("source did not step");
   a_src_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      !srcStep && !(patternMatch && control[dcc_pkg::PATTERN_BIT]) |=> $stable(srcPos))
      else $error("source moved without cause");
   a_dst_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      !dstStep |=> $stable(dstPos))
      else $error("destination moved without cause");
endmodule : dcc_checksum

// ==== dcc_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module dcc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wrIdx;
   logic [AW-1:0]    rdIdx;
   logic [AW:0]      fill;
   logic             doPush;
   logic             doPop;

   assign inReady  = (fill != (AW+1)'(DEPTH));
   assign outValid = (fill != '0);
   assign outData  = store[rdIdx];
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   always_ff @(posedge mclk) begin
      if (doPush) begin
         store[wrIdx] <= inData;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrIdx <= '0;
         rdIdx <= '0;
         fill  <= '0;
      end else begin
         if (doPush) begin
            wrIdx <= (wrIdx == AW'(DEPTH-1)) ? '0 : wrIdx + 1'b1;
         end
         if (doPop) begin
            rdIdx <= (rdIdx == AW'(DEPTH-1)) ? '0 : rdIdx + 1'b1;
         end
         if (doPush && !doPop) begin
            fill <= fill + 1'b1;
         end else if (doPop && !doPush) begin
            fill <= fill - 1'b1;
         end
      end
   end

   // Fill never exceeds depth.
   a_fifo_bound: assert property (@(posedge mclk) disable iff (!rst_n)
      fill <= (AW+1)'(DEPTH)) else $error("fifo fill above depth");
endmodule : dcc_fifo

// ==== dcc_pkg.sv ====
// Package of shared constants for the DMA checksum and channel pointer block.
package dcc_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFF_CONTROL  = 8'h00;
   localparam logic [7:0] OFF_VALUE    = 8'h04;
   localparam logic [7:0] OFF_TAPS     = 8'h08;
   localparam logic [7:0] OFF_SRCPOS   = 8'h0C;
   localparam logic [7:0] OFF_DSTPOS   = 8'h10;
   localparam logic [7:0] OFF_STATUS   = 8'h14;
   // -----------------------------------------------------------------
   // Control fields
   // -----------------------------------------------------------------
   localparam int          KIND_BIT     = 15;
   localparam int          PATTERN_BIT  = 8;
   localparam int          POLYNOMIAL_LENGTH_LSB     = 0;
   localparam int          POLYNOMIAL_LENGTH_W       = 5;
   localparam logic [31:0] CONTROL_MASK = 32'h0000_811F;
   // -----------------------------------------------------------------
   // Reset values and sizes
   // -----------------------------------------------------------------
   localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
   localparam logic [15:0] RESET_POS    = 16'h0000;
   localparam int          FIFO_DEPTH   = 16;
   localparam int          DATA_W       = 8;
endpackage : dcc_pkg

// ==== tb_dma_crc_and_channel_pointers.sv ====
// Self-checking testbench for the DMA checksum and channel pointer block.
`timescale 1ns/10ps
module tb_dma_crc_and_channel_pointers;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   logic        mclk;
   logic        rst_n;
   logic [7:0]  regAddr;
   logic [31:0] regWdata;
   logic        regWrite;
   logic        regRead;
   logic [31:0] regRdata;
   logic [7:0]  moveData;
   logic        moveValid;
   logic        moveReady;
   logic        srcStep;
   logic        dstStep;
   logic        patternMatch;
   logic        busy;
   int          failures;
   int          n_compared;
   logic [31:0] rd;
   logic [31:0] model;
   logic [31:0] taps;
   logic [4:0]  len;
   logic [15:0] acc;
   int          nSrc;
   int          nDst;

   dcc_checksum #(.DATA_W(8), .DEPTH(16)) dut_u (
      .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .moveData(moveData), .moveValid(moveValid), .moveReady(moveReady),
      .srcStep(srcStep), .dstStep(dstStep), .patternMatch(patternMatch), .busy(busy));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // -----------------------------------------------------------------
   // Reference functions and bus tasks
   // -----------------------------------------------------------------
   // Galois shift, MSB first; stage zero always takes the feedback.
   function automatic logic [31:0] lfsr_f(logic [31:0] s, logic [31:0] t,
                                          logic [4:0] l, logic [7:0] d);
      logic        fb;
      logic [31:0] n;
      for (int b = 7; b >= 0; b--) begin
         fb = s[l] ^ d[b];
         n[0] = fb;
         for (int i = 1; i < 32; i++) n[i] = t[i] ? (s[i-1] ^ fb) : s[i-1];
         s = n;
      end
      return s;
   endfunction : lfsr_f

   function automatic logic [15:0] ip_add(logic [15:0] a, logic [7:0] d);
      logic [16:0] s;
      s = {1'b0, a} + {9'h000, d};
      return s[15:0] + {15'h0000, s[16]};
   endfunction : ip_add

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t register read got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rdreg(input logic [7:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 rd = regRdata;
   endtask : rdreg

   // Write then read back to back, with no idle cycle between the two strobes.
   task automatic wrrd(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
      regRead  <= 1'b1;
      @(posedge mclk);
      regRead  <= 1'b0;
      #1 rd = regRdata;
   endtask : wrrd

   // Holds valid and offers a fresh unit after each cycle in which ready was high.
   task automatic push_burst(input int n, input logic ipMode);
      logic [7:0] b;
      int         k;
      k = 0;
      while (k < n) begin
         @(posedge mclk);
         if (moveReady === 1'b1) begin
            b = 8'($urandom);
            moveData  <= b;
            moveValid <= 1'b1;
            if (ipMode) acc = ip_add(acc, b);
            else model = lfsr_f(model, taps, len, b);
            k++;
         end
      end
      @(posedge mclk);
      moveValid <= 1'b0;
      repeat (3) @(posedge mclk);
      k = 0;
      while (busy !== 1'b0 && k < 50) begin
         @(posedge mclk);
         k++;
      end
      if (k == 50) chk(32'h0000_0001, 32'h0000_0000);
      repeat (2) @(posedge mclk);
   endtask : push_burst

   task automatic pulses(input logic s, input logic d, input logic p, input int n);
      repeat (n) begin
         @(posedge mclk);
         srcStep      <= s;
         dstStep      <= d;
         patternMatch <= p;
      end
      @(posedge mclk);
      srcStep      <= 1'b0;
      dstStep      <= 1'b0;
      patternMatch <= 1'b0;
   endtask : pulses

   task automatic stop_test;
      if (failures == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   // -----------------------------------------------------------------
   // Watchdog
   // -----------------------------------------------------------------
   // The dest pointer walk dominates the run, so the limit sits about a third above it.
   initial begin
      repeat (90000) @(posedge mclk);
      failures++;
      stop_test();
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      failures = 0;
      n_compared = 0;
      rst_n = 1'b0;
      {regAddr, regWdata, regWrite, regRead} = '0;
      {moveData, moveValid, srcStep, dstStep, patternMatch} = '0;
      void'($urandom(32'h6CA8));
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      for (int a = 0; a <= 20; a += 4) begin
         rdreg(8'(a));
         chk(rd, 32'h0000_0000);
      end
      taps = $urandom;
      wr(dcc_pkg::OFF_TAPS, taps);
      wr(8'h40, 32'hFFFF_FFFF);
      rdreg(8'h40);
      chk(rd, 32'h0000_0000);
      rdreg(dcc_pkg::OFF_TAPS);
      chk(rd, taps);
      for (int k = 0; k < 4; k++) begin
         len = (k == 0) ? 5'h1F : 5'($urandom_range(30, 1));
         taps = (k == 1) ? 32'h0000_0000 : (k == 2) ? 32'hFFFF_FFFF : $urandom;
         model = $urandom;
         wr(dcc_pkg::OFF_CONTROL, {27'h0000000, len});
         wr(dcc_pkg::OFF_TAPS, taps);
         wr(dcc_pkg::OFF_VALUE, model);
         rdreg(dcc_pkg::OFF_VALUE);
         chk(rd, model & (32'hFFFF_FFFF >> (5'h1F - len)));
         push_burst(8, 1'b0);
         rdreg(dcc_pkg::OFF_VALUE);
         chk(rd, model & (32'hFFFF_FFFF >> (5'h1F - len)));
      end
      wr(dcc_pkg::OFF_CONTROL, 32'h0000_8000);
      wr(dcc_pkg::OFF_TAPS, $urandom);
      model = $urandom;
      wrrd(dcc_pkg::OFF_VALUE, model);
      chk(rd, {16'h0000, model[15:0]});
      acc = ~model[15:0];
      push_burst(12, 1'b1);
      rdreg(dcc_pkg::OFF_VALUE);
      chk(rd, {16'h0000, ~acc});
      wr(dcc_pkg::OFF_CONTROL, 32'h0000_0100);
      nSrc = $urandom_range(20, 3);
      nDst = $urandom_range(20, 3);
      pulses(1'b1, 1'b0, 1'b0, nSrc);
      pulses(1'b0, 1'b1, 1'b0, nDst);
      rdreg(dcc_pkg::OFF_SRCPOS);
      chk(rd, 32'(nSrc));
      pulses(1'b1, 1'b0, 1'b1, 1);
      rdreg(dcc_pkg::OFF_SRCPOS);
      chk(rd, 32'h0000_0000);
      wr(dcc_pkg::OFF_CONTROL, 32'h0000_0000);
      pulses(1'b1, 1'b0, 1'b0, 2);
      pulses(1'b0, 1'b0, 1'b1, 1);
      rdreg(dcc_pkg::OFF_SRCPOS);
      chk(rd, 32'h0000_0002);
      wr(dcc_pkg::OFF_SRCPOS, 32'hFFFF_FFFF);
      rdreg(dcc_pkg::OFF_SRCPOS);
      chk(rd, 32'h0000_0002);
      pulses(1'b0, 1'b1, 1'b0, 65535 - nDst);
      rdreg(dcc_pkg::OFF_DSTPOS);
      chk(rd, 32'h0000_FFFF);
      stop_test();
   end
endmodule : tb_dma_crc_and_channel_pointers
